//--- design/eeac_pkg.sv
// package: register map, field layout and timing constants for the eeprom access block
`default_nettype none
package eeac_pkg;
  // register byte offsets, one 32-bit word each
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_ADDRESS = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_CORE = 4'hc;
  // control field positions
  localparam int BIT_READ = 0;
  localparam int BIT_PROG = 1;
  localparam int BIT_MASTER = 2;
  localparam int BIT_RIE = 3;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_MODE_HI = 5;
  // core register field positions
  localparam int BIT_GIE = 0;
  localparam int BIT_SELFPRG = 1;
  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [11:0] RST_ADDR = 12'h000;
  localparam logic [7:0] RST_DATA = 8'h00;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int ARM_CYCLES = 4;
  localparam int WSTALL_CYCLES = 2;
  localparam int RSTALL_CYCLES = 4;
  localparam int RC_WRITE_CYCLES = 26368;
  localparam int T_ATOMIC_US = 3400;
  localparam int T_SPLIT_US = 1800;
  localparam int T_TYP_WRITE_US = 3300;
  // rc ticks for the atomic and split (erase, write) modes, scaled from the typical write time
  localparam int RC_ATOMIC = (RC_WRITE_CYCLES * T_ATOMIC_US) / T_TYP_WRITE_US;
  localparam int RC_SPLIT = (RC_WRITE_CYCLES * T_SPLIT_US) / T_TYP_WRITE_US;
  // programming modes
  typedef enum logic [1:0]
  {
    EEAC_ATOMIC = 2'b00,
    EEAC_ERASE = 2'b01,
    EEAC_WRITE = 2'b10,
    EEAC_RSVD = 2'b11
  } eeac_mode_t;
  // array command bundle
  typedef struct packed
  {
    logic [11:0] addr;
    logic [7:0] wdata;
    eeac_mode_t mode;
  } eeac_cmd_t;
endpackage
`default_nettype wire

//--- design/eeac_timer.sv
// programming timer counting calibrated rc oscillator ticks
`default_nettype none
module eeac_timer
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [15:0] i_len,
  input wire logic i_tick,
  output logic o_busy,
  output logic o_done
);
  logic [15:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  // reset is ignored while busy so a write runs to completion
  always_ff @(posedge i_clk)
  begin
    done_ff <= 1'b0;
    if (busy_ff)
    begin
      if (i_tick)
      begin
        if (cnt_ff <= 16'h0001)
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          cnt_ff <= 16'h0000;
        end
        else
        begin
          cnt_ff <= cnt_ff - 16'h0001;
        end
      end
    end
    else if (i_rst)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end
    else if (i_start)
    begin
      busy_ff <= 1'b1;
      cnt_ff <= i_len;
    end
  end
  assign o_busy = busy_ff;
  assign o_done = done_ff;
endmodule
`default_nettype wire

//--- design/eeac_top.sv
// eeprom access control: avalon-mm registers, arming, timing, stalls and array port
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`default_nettype none
module eeac_top
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // avalon-mm slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // calibrated rc oscillator, asynchronous level
  input wire logic I_RC_OSC,
  // array port
  output eeac_pkg::eeac_cmd_t O_ARR_CMD,
  output logic O_ARR_PROG,
  output logic O_ARR_READ,
  input wire logic [7:0] I_ARR_RDATA,
  // core side
  output logic O_CPU_STALL,
  output logic O_READY_IRQ
);
  logic rc_s1_ff;
  logic rc_s2_ff;
  logic rc_s3_ff;
  logic rc_tick;
  logic [1:0] mode_ff;
  logic rie_ff;
  logic master_ff;
  logic [2:0] arm_cnt_ff;
  logic prog_ff;
  logic [11:0] addr_ff;
  logic [7:0] data_ff;
  logic gie_ff;
  logic selfprg_ff;
  logic ack_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [2:0] stall_cnt_ff;
  logic stall_ff;
  logic irq_ff;
  logic arr_prog_ff;
  logic arr_read_ff;
  logic rd_pend_ff;
  logic busy;
  logic done;
  logic start;
  logic [15:0] len;
  logic wr_ctl;
  logic wr_adr;
  logic wr_dat;
  logic wr_core;
  logic [7:0] wb;
  logic [31:0] nxt_rdata;

  // two flops on the rc pin, then an edge detect on synchronised copies only
  always_ff @(posedge I_CLK_SYS)
  begin
    rc_s1_ff <= I_RC_OSC;
    rc_s2_ff <= rc_s1_ff;
    rc_s3_ff <= rc_s2_ff;
  end
  assign rc_tick = rc_s2_ff && !rc_s3_ff;

  // one-cycle accept: waitrequest drops for a single edge per request
  assign wb = I_AVS_WRITEDATA[7:0];
  assign wr_ctl = I_AVS_WRITE && !ack_ff && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS == eeac_pkg::OFS_CONTROL;
  assign wr_adr = I_AVS_WRITE && !ack_ff && I_AVS_ADDRESS == eeac_pkg::OFS_ADDRESS;
  assign wr_dat = I_AVS_WRITE && !ack_ff && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS == eeac_pkg::OFS_DATA;
  assign wr_core = I_AVS_WRITE && !ack_ff && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS == eeac_pkg::OFS_CORE;

  // waitrequest high until the slave has latched the request
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
    end
    else
    begin
      ack_ff <= (I_AVS_READ || I_AVS_WRITE) && !ack_ff;
      wait_ff <= !((I_AVS_READ || I_AVS_WRITE) && !ack_ff); // registered copy keeps the pin off logic
    end
  end
  assign O_AVS_WAITREQUEST = wait_ff;

  // programming mode field
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      if (!busy)
      begin
        mode_ff <= eeac_pkg::RST_MODE;
      end
    end
    else if (wr_ctl && !prog_ff)
    begin
      mode_ff <= wb[eeac_pkg::BIT_MODE_HI:eeac_pkg::BIT_MODE_LO];
    end
  end

  // ready interrupt enable and core-status bits
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      rie_ff <= 1'b0;
      gie_ff <= 1'b0;
      selfprg_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        rie_ff <= wb[eeac_pkg::BIT_RIE];
      end
      if (wr_core)
      begin
        gie_ff <= wb[eeac_pkg::BIT_GIE];
        selfprg_ff <= wb[eeac_pkg::BIT_SELFPRG];
      end
    end
  end

  // arming window: master enable lives for four cycles then clears itself
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      master_ff <= 1'b0;
      arm_cnt_ff <= 3'h0;
    end
    else if (wr_ctl && wb[eeac_pkg::BIT_MASTER] && !wb[eeac_pkg::BIT_PROG])
    begin
      master_ff <= 1'b1;
      arm_cnt_ff <= 3'(eeac_pkg::ARM_CYCLES);
    end
    else if (master_ff)
    begin
      if (arm_cnt_ff == 3'h1)
      begin
        master_ff <= 1'b0;
      end
      arm_cnt_ff <= arm_cnt_ff - 3'h1;
    end
  end

  // start needs a live arm; a flash self-write in progress does not block it, it only drops the array pulse (software should check)
  assign start = wr_ctl && wb[eeac_pkg::BIT_PROG] && master_ff && !prog_ff && !busy;

  // mode selects the timer length
  always_comb
  begin
    case (eeac_pkg::eeac_mode_t'(mode_ff))
      eeac_pkg::EEAC_ATOMIC: len = 16'(eeac_pkg::RC_ATOMIC);
      eeac_pkg::EEAC_ERASE: len = 16'(eeac_pkg::RC_SPLIT);
      eeac_pkg::EEAC_WRITE: len = 16'(eeac_pkg::RC_SPLIT);
      default: len = 16'(eeac_pkg::RC_WRITE_CYCLES);
    endcase
  end

  eeac_timer u_timer
  (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_start(start),
    .i_len(len),
    .i_tick(rc_tick),
    .o_busy(busy),
    .o_done(done)
  );

  // program enable set at start, cleared by hardware at time-out
  always_ff @(posedge I_CLK_SYS)
  begin
    if (done)
    begin
      prog_ff <= 1'b0;
    end
    else if (I_RST && !busy)
    begin
      prog_ff <= 1'b0;
    end
    else if (start)
    begin
      prog_ff <= 1'b1;
    end
    else if (busy)
    begin
      prog_ff <= 1'b1;
    end
  end

  // address register frozen during a write, reset included; data register frozen only against bus writes
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST && !busy)
    begin
      addr_ff <= eeac_pkg::RST_ADDR;
    end
    else if (wr_adr && !prog_ff)
    begin
      if (I_AVS_BYTEENABLE[0])
      begin
        addr_ff[7:0] <= I_AVS_WRITEDATA[7:0];
      end
      if (I_AVS_BYTEENABLE[1])
      begin
        addr_ff[11:8] <= I_AVS_WRITEDATA[11:8];
      end
    end
  end

  // array read returns the next cycle; data register takes it then
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      data_ff <= eeac_pkg::RST_DATA;
      rd_pend_ff <= 1'b0;
    end
    else
    begin
      rd_pend_ff <= arr_read_ff;
      if (rd_pend_ff)
      begin
        data_ff <= I_ARR_RDATA;
      end
      else if (wr_dat && !prog_ff)
      begin
        data_ff <= wb;
      end
    end
  end

  // array strobes
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      arr_prog_ff <= 1'b0;
      arr_read_ff <= 1'b0;
    end
    else
    begin
      arr_prog_ff <= start && !selfprg_ff;
      arr_read_ff <= wr_ctl && wb[eeac_pkg::BIT_READ] && !prog_ff;
    end
  end
  assign O_ARR_PROG = arr_prog_ff;
  assign O_ARR_READ = arr_read_ff;
  assign O_ARR_CMD = '{addr: addr_ff, wdata: data_ff, mode: eeac_pkg::eeac_mode_t'(mode_ff)};

  // core stall: two cycles after a write start, four after a read
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      stall_cnt_ff <= 3'h0;
      stall_ff <= 1'b0;
    end
    else if (start)
    begin
      stall_cnt_ff <= 3'(eeac_pkg::WSTALL_CYCLES - 1);
      stall_ff <= 1'b1;
    end
    else if (wr_ctl && wb[eeac_pkg::BIT_READ] && !prog_ff)
    begin
      stall_cnt_ff <= 3'(eeac_pkg::RSTALL_CYCLES - 1);
      stall_ff <= 1'b1;
    end
    else if (stall_cnt_ff != 3'h0)
    begin
      stall_cnt_ff <= stall_cnt_ff - 3'h1;
    end
    else
    begin
      stall_ff <= 1'b0;
    end
  end
  assign O_CPU_STALL = stall_ff;

  // level ready request, gated by both enables
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= rie_ff && gie_ff && !prog_ff;
    end
  end
  assign O_READY_IRQ = irq_ff;

  // read mux; strobe bit reads zero, unmapped words read zero
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (I_AVS_ADDRESS)
      eeac_pkg::OFS_CONTROL: nxt_rdata[7:0] = {2'b00, mode_ff, rie_ff, master_ff, prog_ff, 1'b0};
      eeac_pkg::OFS_ADDRESS: nxt_rdata[11:0] = addr_ff;
      eeac_pkg::OFS_DATA: nxt_rdata[7:0] = data_ff;
      eeac_pkg::OFS_CORE: nxt_rdata[1:0] = {selfprg_ff, gie_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (I_AVS_READ && !ack_ff)
    begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign O_AVS_READDATA = rdata_ff;
endmodule
`default_nettype wire

//--- dv/eeac_props.sv
// checker: port timing of the eeprom access block
`default_nettype none
module eeac_props
(
  // clock, reset, bus
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST,
  // array and core
  input wire eeac_pkg::eeac_cmd_t O_ARR_CMD,
  input wire logic O_ARR_PROG,
  input wire logic O_ARR_READ,
  input wire logic O_CPU_STALL,
  input wire logic O_READY_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  // a pending request is answered on the next edge
  bus_ack_a: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("late ack");
  // a program pulse is not repeated in the eight cycles after it
  prog_once_a: assert property (O_ARR_PROG |=> !O_ARR_PROG [*8])
    else $error("restart");
  read_once_a: assert property (O_ARR_READ |=> !O_ARR_READ)
    else $error("long read");
  wr_stall_a: assert property (O_ARR_PROG |-> ##[0:2] O_CPU_STALL)
    else $error("no write stall");
  rd_stall_a: assert property (O_ARR_READ |-> ##[0:2] O_CPU_STALL)
    else $error("no read stall");
  // stall lasts two cycles or four, never another length
  stall_len_a: assert property ($rose(O_CPU_STALL) |-> O_CPU_STALL [*2] ##1
    (!O_CPU_STALL or O_CPU_STALL [*2] ##1 !O_CPU_STALL)) else $error("stall length");
  irq_busy_a: assert property (O_ARR_PROG |-> ##[0:2] !O_READY_IRQ ##1 !O_READY_IRQ [*8])
    else $error("irq while busy");
  // address, data and mode held for eight cycles after the program pulse
  cmd_hold_a: assert property (O_ARR_PROG |=> $stable(O_ARR_CMD) [*8])
    else $error("cmd moved");
endmodule
bind eeac_top eeac_props u_props (.I_CLK_SYS, .I_RST, .I_AVS_READ, .I_AVS_WRITE, .O_AVS_WAITREQUEST,
  .O_ARR_CMD, .O_ARR_PROG, .O_ARR_READ, .O_CPU_STALL, .O_READY_IRQ);
`default_nettype wire

//--- dv/eeac_array_model.sv
// far-side model: eeprom byte array answering program and read pulses
`default_nettype none
module eeac_array_model
(
  // clock
  input wire logic i_clk,
  // array port
  input wire eeac_pkg::eeac_cmd_t i_cmd,
  input wire logic i_prog,
  input wire logic i_read,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  function automatic logic [7:0] rd(input logic [11:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5a;
  endfunction
  initial o_rdata = 8'h00;
  // erase leaves ff, write-only can only clear bits; idle bus toggles so stale data never matches
  always @(posedge i_clk)
  begin
    if (i_prog)
      mem[i_cmd.addr] = i_cmd.mode == eeac_pkg::EEAC_ERASE ? 8'hff :
        i_cmd.mode == eeac_pkg::EEAC_WRITE ? rd(i_cmd.addr) & i_cmd.wdata : i_cmd.wdata;
    o_rdata <= i_read ? rd(i_cmd.addr) : ~o_rdata;
  end
endmodule
`default_nettype wire

//--- dv/eeac_top_tb_top.sv
// bench: register scenarios checked against a byte model
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module eeac_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ctl = eeac_pkg::OFS_CONTROL;
  localparam logic [3:0] ad = eeac_pkg::OFS_ADDRESS;
  localparam logic [3:0] dt = eeac_pkg::OFS_DATA;
  localparam logic [31:0] prg = 32'h1 << eeac_pkg::BIT_PROG;
  localparam logic [31:0] mm = 32'h3 << eeac_pkg::BIT_MODE_LO;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic av_r = 1'b0;
  logic av_w = 1'b0;
  logic rc = 1'b0;
  logic [3:0] av_a = 4'h0;
  logic [31:0] av_d = 32'h0;
  logic [31:0] av_q, q;
  logic [31:0] rs = 32'h63; // xorshift seed 99
  logic [7:0] ar_q;
  logic [11:0] ra;
  logic wreq, aprog, aread, stall, irq;
  eeac_pkg::eeac_cmd_t cmd, pcmd;
  int n_errors = 0, check_count = 0, np = 0, nr = 0, cyc = 0, ns = 0, s0 = 0;
  logic [7:0] bm [int];
  eeac_top dut (.I_CLK_SYS(clk), .I_RST(rst), .I_AVS_ADDRESS(av_a), .I_AVS_READ(av_r), .I_AVS_WRITE(av_w),
    .I_AVS_WRITEDATA(av_d), .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(av_q), .O_AVS_WAITREQUEST(wreq),
    .I_RC_OSC(rc), .O_ARR_CMD(cmd), .O_ARR_PROG(aprog), .O_ARR_READ(aread), .I_ARR_RDATA(ar_q),
    .O_CPU_STALL(stall), .O_READY_IRQ(irq));
  eeac_array_model u_arr (.i_clk(clk), .i_cmd(cmd), .i_prog(aprog), .i_read(aread), .o_rdata(ar_q));
  always #2 clk = ~clk;
  // oscillator at half the clock rate keeps the long write times inside the run budget
  always @(posedge clk)
  begin
    rc <= ~rc;
    cyc++;
    np += int'(aprog === 1'b1);
    nr += int'(aread === 1'b1);
    ns += int'(stall === 1'b1);
    if (aprog === 1'b1)
      pcmd = cmd;
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // expected byte: last programmed value, else the array's power-up pattern
  function automatic logic [7:0] ex(input logic [11:0] a);
    return bm.exists(a) ? bm[a] : a[7:0] ^ 8'h5a;
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one transfer; q takes read data at the acknowledging edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    av_a <= a;
    av_w <= w;
    av_r <= !w;
    av_d <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wreq !== 1'b0 && k < 50);
    q = av_q;
    av_w <= 1'b0;
    av_r <= 1'b0;
    if (k >= 50)
    begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic rst_pulse();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  // armed write disturbed by refused accesses and a reset, timed to the ready request
  task automatic wr_byte(input logic [11:0] a, input logic [7:0] d, input logic [1:0] md, input int ticks);
    int t0, n0, p0;
    logic [31:0] m;
    m = 32'(md) << eeac_pkg::BIT_MODE_LO;
    n0 = nr;
    p0 = np;
    bus(1'b1, ad, {20'h0, a});
    bus(1'b1, dt, {24'h0, d});
    s0 = ns;
    bus(1'b1, ctl, m | 32'h1 << eeac_pkg::BIT_MASTER);
    bus(1'b1, ctl, prg | m);
    t0 = cyc;
    bus(1'b1, ctl, prg | (m ^ 32'h2 << eeac_pkg::BIT_MODE_LO));
    bus(1'b1, ad, {20'h0, ~a});
    bus(1'b1, ctl, prg | m | 32'h1 << eeac_pkg::BIT_READ);
    `CHK("starts", p0 + 1, np)
    `CHK("write stall", eeac_pkg::WSTALL_CYCLES, ns - s0)
    `CHK("cmd", {a, d, md}, pcmd)
    rst_pulse();
    bus(1'b0, ctl, 32'h0);
    `CHK("ctl busy", prg | m, q & (prg | mm))
    bus(1'b0, ad, 32'h0);
    `CHK("addr busy", {20'h0, a}, q)
    `CHK("reads busy", n0, nr)
    bus(1'b1, eeac_pkg::OFS_CORE, 32'h1 << eeac_pkg::BIT_GIE);
    // a fully armed second start while busy must not restart the timer
    bus(1'b1, ctl, m | 32'h1 << eeac_pkg::BIT_MASTER);
    bus(1'b1, ctl, prg | m | 32'h1 << eeac_pkg::BIT_RIE);
    `CHK("irq busy", 1'b0, irq)
    while (irq !== 1'b1 && cyc - t0 < 60000)
      @(posedge clk);
    `CHK("time", 1'b1, cyc - t0 >= 2 * ticks - 4 && cyc - t0 <= 2 * ticks + 24)
    `CHK("one start", p0 + 1, np)
    if (irq !== 1'b1)
      end_of_test();
    repeat (3) @(posedge clk);
    `CHK("irq level", 1'b1, irq)
    bus(1'b0, ctl, 32'h0);
    `CHK("prog done", 32'h0, q & prg)
    bus(1'b1, ctl, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq off", 1'b0, irq)
    bus(1'b1, ctl, 32'h1 << eeac_pkg::BIT_RIE);
    bus(1'b1, eeac_pkg::OFS_CORE, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq gie", 1'b0, irq)
    bm[a] = md == 2'b01 ? 8'hff : md == 2'b10 ? ex(a) & d : d;
    bus(1'b1, ad, {20'h0, a});
    bus(1'b1, ctl, 32'h1 << eeac_pkg::BIT_READ);
    bus(1'b0, dt, 32'h0);
    `CHK("read back", {24'h0, ex(a)}, q)
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, ctl, 32'h0);
    `CHK("ctl reset", 32'h0, q)
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, ctl, 32'(m) << eeac_pkg::BIT_MODE_LO);
      bus(1'b0, ctl, 32'h0);
      `CHK("mode", 32'(m) << eeac_pkg::BIT_MODE_LO, q)
    end
    rst_pulse();
    bus(1'b0, ctl, 32'h0);
    `CHK("mode reset", 32'h0, q & mm)
    q = rnd();
    bus(1'b1, ad, q);
    bus(1'b0, ad, 32'h0);
    `CHK("addr", {20'h0, rs[11:0]}, q)
    ra = rs[11:0];
    bus(1'b1, dt, rnd());
    bus(1'b0, dt, 32'h0);
    `CHK("data", {24'h0, rs[7:0]}, q)
    // unarmed and late program requests start nothing
    bus(1'b1, ctl, prg);
    bus(1'b1, ctl, 32'h1 << eeac_pkg::BIT_MASTER);
    repeat (4) @(posedge clk);
    bus(1'b1, ctl, prg);
    bus(1'b0, ctl, 32'h0);
    `CHK("no start", 0, np)
    `CHK("prog idle", 32'h0, q & prg)
    s0 = ns;
    bus(1'b1, ctl, 32'h1 << eeac_pkg::BIT_READ);
    bus(1'b0, dt, 32'h0);
    `CHK("read", 1, nr)
    `CHK("read data", {24'h0, ex(ra)}, q)
    // let the stall counter settle before comparing it
    repeat (2) @(posedge clk);
    `CHK("read stall", eeac_pkg::RSTALL_CYCLES, ns - s0)
    wr_byte(12'(rnd()), 8'(rnd()), 2'b01, eeac_pkg::RC_SPLIT);
    wr_byte(12'(rnd()), 8'(rnd()), 2'b00, eeac_pkg::RC_ATOMIC);
    end_of_test();
  end
endmodule
`default_nettype wire
